// file: verilog/can_message_object_handler.sv
`timescale 1ns/1ns
`include "can_moh_defs.svh"
module can_message_object_handler #(
	parameter int NumObj = `OBJ_COUNT
) (
	input  wire logic        clk,
	input  wire logic        rst_b,
	can_moh_if.handler       ifc,
	input  wire logic        rxValid,
	input  wire logic [28:0] rxId,
	input  wire logic        rxXtd,
	input  wire logic        rxRemote,
	input  wire logic [3:0]  rxDlc,
	input  wire logic [63:0] rxData,
	input  wire logic        txReady,
	input  wire logic        txDone,
	input  wire logic        txFail,
	output logic             txStart_ff,
	output logic [5:0]       txObj_ff,
	output logic [28:0]      txId_ff,
	output logic             txXtd_ff,
	output logic             txRemote_ff,
	output logic [3:0]       txDlc_ff,
	output logic [63:0]      txData_ff
);
	localparam int IW = $clog2(NumObj);

	// Object store, one entry per message object
	can_moh_pkg::arb_t  arbMem [NumObj];
	can_moh_pkg::mask_t mskMem [NumObj];
	can_moh_pkg::ctl_t  ctlMem [NumObj];
	logic [63:0]        dataMem [NumObj];

	can_moh_pkg::hstate_t state_ff;
	logic [IW-1:0]        scanIdx_ff;
	logic [28:0]          frId_ff;
	logic                 frXtd_ff;
	logic                 frRemote_ff;
	logic [3:0]           frDlc_ff;
	logic [63:0]          frData_ff;
	logic                 txBusy_ff;
	logic [IW-1:0]        txIdx_ff;
	logic [NumObj-1:0]    pendVec;
	logic [NumObj-1:0]    pndVec;
	logic [5:0]           pick;
	logic [5:0]           pickM1;
	logic [IW-1:0]        pickIdx;
	logic [5:0]           cmdM1;
	logic [IW-1:0]        cmdIdx;
	logic                 cmdOk;
	logic                 cmdTake;
	logic                 txTake;
	logic                 hit;
	logic [28:0]          idMask;
	logic                 useMask;
	logic                 scanning;

	// Lowest set bit as object number 1..N, zero when none
	function automatic logic [5:0] firstSet(input logic [NumObj-1:0] v);
		logic [5:0] n;
		n = 6'h00;
		for (int i = NumObj - 1; i >= 0; i--) begin
			if (v[i])
				n = 6'(i + 1);
		end
		return n;
	endfunction

	// Pending transmit and interrupt vectors
	always_comb begin
		for (int i = 0; i < NumObj; i++) begin
			pendVec[i] = arbMem[i].objectValid & ctlMem[i].transmitRequest;
			pndVec[i] = ctlMem[i].interruptPending;
		end
	end

	// Object number decode and arbitration between users of the store
	assign pick = firstSet(pendVec); // R15
	assign pickM1 = pick - 6'h01;
	assign pickIdx = pickM1[IW-1:0];
	assign cmdM1 = ifc.objectNumber - 6'h01;
	assign cmdIdx = cmdM1[IW-1:0];
	assign cmdOk = (ifc.objectNumber != 6'h00) && (ifc.objectNumber <= NumObj);
	assign scanning = (state_ff == can_moh_pkg::ST_SCAN);
	// Reception outranks host transfers; frames cannot wait
	assign cmdTake = !scanning && !rxValid && ifc.cmdValid && !ifc.cmdDone;
	// No load into the shifter while a transfer is in flight
	assign txTake = !scanning && !rxValid && !ifc.cmdValid && txReady &&
		!txBusy_ff && (pick != 6'h00);

	// Acceptance test of the object under the scan pointer
	always_comb begin
		useMask = ctlMem[scanIdx_ff].maskUse; // R19
		idMask = useMask ? mskMem[scanIdx_ff].acceptanceMaskBits : '1; // R5
		if (!frXtd_ff)
			idMask = idMask & `STD_ID_MASK; // R18
		hit = arbMem[scanIdx_ff].objectValid && scanning &&
			(((arbMem[scanIdx_ff].id ^ frId_ff) & idMask) == 29'h0) &&
			((useMask && !mskMem[scanIdx_ff].maskExtendedSelect) ||
			 (arbMem[scanIdx_ff].extendedFrameFlag == frXtd_ff)) && // R19
			((useMask && !mskMem[scanIdx_ff].maskSenseSelect) ||
			 (arbMem[scanIdx_ff].direction == frRemote_ff)); // R19
	end

	// Scan sequencer
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_ff <= can_moh_pkg::ST_IDLE;
			scanIdx_ff <= '0;
		end else if (rxValid) begin
			state_ff <= can_moh_pkg::ST_SCAN; // R5
			scanIdx_ff <= '0; // R6
		end else if (scanning) begin
			if (hit || scanIdx_ff == IW'(NumObj - 1))
				state_ff <= can_moh_pkg::ST_IDLE; // R6
			else
				scanIdx_ff <= scanIdx_ff + 1'b1; // R6
		end
	end

	// Incoming frame capture, header and data held for the scan
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			frId_ff <= '0;
			frXtd_ff <= 1'b0;
			frRemote_ff <= 1'b0;
			frDlc_ff <= '0;
			frData_ff <= '0;
		end else if (rxValid) begin
			frId_ff <= rxId;
			frXtd_ff <= rxXtd;
			frRemote_ff <= rxRemote;
			frDlc_ff <= rxDlc;
			frData_ff <= rxData;
		end
	end

	// Object store updates; later statements win, so sets beat clears
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < NumObj; i++) begin
				arbMem[i] <= '0;
				mskMem[i] <= '0;
				ctlMem[i] <= '0;
				dataMem[i] <= '0;
			end
		end else begin
			// Request stays if new data arrived since the start
			if (txDone && txBusy_ff && !ctlMem[txIdx_ff].newDataFlag)
				ctlMem[txIdx_ff].transmitRequest <= 1'b0; // R4
			if (txTake)
				ctlMem[pickIdx].newDataFlag <= 1'b0; // R4
			if (cmdTake && cmdOk) begin
				if (ifc.cmdMask.writeNotRead) begin
					if (ifc.cmdMask.maskTransfer)
						mskMem[cmdIdx] <= ifc.ifMask;
					if (ifc.cmdMask.arbTransfer)
						arbMem[cmdIdx] <= ifc.ifArb; // R20
					if (ifc.cmdMask.controlTransfer)
						ctlMem[cmdIdx] <= ifc.ifCtl; // R4
					else if (ifc.cmdMask.transmitRequest)
						ctlMem[cmdIdx].transmitRequest <= 1'b1; // R3
					// Whole words only; partial bytes are not merged
					if (ifc.cmdMask.dataATransfer)
						dataMem[cmdIdx][31:0] <= ifc.ifData[31:0]; // R1
					if (ifc.cmdMask.dataBTransfer)
						dataMem[cmdIdx][63:32] <= ifc.ifData[63:32]; // R1
				end else begin
					if (ifc.cmdMask.clearPending)
						ctlMem[cmdIdx].interruptPending <= 1'b0;
					if (ifc.cmdMask.transmitRequest)
						ctlMem[cmdIdx].newDataFlag <= 1'b0;
				end
			end
			if (txDone && txBusy_ff && ctlMem[txIdx_ff].txIrqEnable)
				ctlMem[txIdx_ff].interruptPending <= 1'b1;
			if (hit && !frRemote_ff) begin
				dataMem[scanIdx_ff] <= frData_ff; // R21
				arbMem[scanIdx_ff].id <= frId_ff; // R7
				arbMem[scanIdx_ff].extendedFrameFlag <= frXtd_ff; // R7
				ctlMem[scanIdx_ff].dlc <= frDlc_ff; // R7
				ctlMem[scanIdx_ff].newDataFlag <= 1'b1; // R7
				if (ctlMem[scanIdx_ff].newDataFlag)
					ctlMem[scanIdx_ff].messageLost <= 1'b1; // R8
				if (ctlMem[scanIdx_ff].receiveIrqEnable)
					ctlMem[scanIdx_ff].interruptPending <= 1'b1; // R9
				// Pending remote request is answered already
				ctlMem[scanIdx_ff].transmitRequest <= 1'b0; // R23
			end else if (hit && arbMem[scanIdx_ff].direction) begin
				if (ctlMem[scanIdx_ff].remoteEnable) begin
					ctlMem[scanIdx_ff].transmitRequest <= 1'b1; // R12
				end else if (ctlMem[scanIdx_ff].maskUse) begin
					ctlMem[scanIdx_ff].transmitRequest <= 1'b0; // R14
					arbMem[scanIdx_ff].id <= frId_ff; // R14
					arbMem[scanIdx_ff].extendedFrameFlag <= frXtd_ff; // R14
					ctlMem[scanIdx_ff].dlc <= frDlc_ff; // R14
					ctlMem[scanIdx_ff].newDataFlag <= 1'b1; // R14
					if (ctlMem[scanIdx_ff].newDataFlag)
						ctlMem[scanIdx_ff].messageLost <= 1'b1; // R8
				end
				// Neither enable nor mask: frame dropped silently R13
			end
			// Lost flag is never cleared here; only a control write R24
		end
	end

	// Host transfer answer and read-back
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ifc.cmdDone <= 1'b0;
			ifc.rdArb <= '0;
			ifc.rdMask <= '0;
			ifc.rdCtl <= '0;
			ifc.rdData <= '0;
		end else begin
			ifc.cmdDone <= cmdTake;
			if (cmdTake && cmdOk && !ifc.cmdMask.writeNotRead) begin
				ifc.rdArb <= arbMem[cmdIdx];
				ifc.rdMask <= mskMem[cmdIdx];
				ifc.rdCtl <= ctlMem[cmdIdx];
				ifc.rdData <= dataMem[cmdIdx];
			end
		end
	end

	// Interrupt identifier: lowest pending object
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			ifc.intId <= `RST_OBJ;
		else
			ifc.intId <= firstSet(pndVec); // R9
	end

	// Transmit launch; retries re-arbitrate by object number
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			txStart_ff <= 1'b0;
			txBusy_ff <= 1'b0;
			txIdx_ff <= '0;
			txObj_ff <= `RST_OBJ;
			txId_ff <= '0;
			txXtd_ff <= 1'b0;
			txRemote_ff <= 1'b0;
			txDlc_ff <= '0;
			txData_ff <= '0;
		end else begin
			txStart_ff <= txTake;
			if (txTake) begin
				txBusy_ff <= 1'b1;
				txIdx_ff <= pickIdx;
				txObj_ff <= pick; // R15
				txId_ff <= arbMem[pickIdx].id;
				txXtd_ff <= arbMem[pickIdx].extendedFrameFlag;
				txRemote_ff <= !arbMem[pickIdx].direction; // R23
				txDlc_ff <= ctlMem[pickIdx].dlc;
				txData_ff <= dataMem[pickIdx]; // R12
			end else if (txDone || txFail) begin
				txBusy_ff <= 1'b0;
			end
		end
	end
endmodule // can_message_object_handler

// file: verilog/can_moh_defs.svh
`ifndef CAN_MOH_DEFS_SVH
`define CAN_MOH_DEFS_SVH
// Operation
// R1: Data updates accepted anytime, no valid clear
// R2: Host fills all data bytes before transfer
// R3: Data-only update: mask bits, data, number
// R4: New-data plus request: keep request, clear later
// R5: After header, scan RAM, mask when enabled
// R6: Ascending scan from object 1, first match
// R7: Data frame stores data, arbitration, length
// R8: Store over set new-data sets message-lost
// R9: Receive irq enable sets pending, identifier
// R10: Host clears new-data when reading object
// R11: Receive object keeps request bit cleared
// R12: Remote, remote-enable: set request, send
// R13: Remote, no enable, no mask: ignore
// R14: Remote, no enable, mask: store header
// R15: Lowest object number transmits first
// R16: Host sets identifier, valid, receive direction
// R17: Host sets receive control fields, flags clear
// R18: Upper mask maps extended and standard bits
// R19: Extended, direction masks need mask-use
// R20: Written object becomes active for reception
// R21: Stored frame puts byte 0 lowest
// R22: Host sets mask-extended for extended only
// R23: Receive request sends remote, cleared by data
// R24: Message-lost cleared only by host

// Object store geometry
`define OBJ_COUNT 32
`define STD_ID_MASK 29'h1FFC0000

// Register byte offsets of the host block
`define OFS_CMD_MASK 8'h00
`define OFS_CMD_REQ 8'h04
`define OFS_ARB 8'h08
`define OFS_MASK 8'h0C
`define OFS_CTL 8'h10
`define OFS_DATA_A 8'h14
`define OFS_DATA_B 8'h18
`define OFS_STATUS 8'h1C

// Status field positions
`define STAT_BUSY_BIT 0
`define STAT_INTID_LSB 8
`define STAT_INTID_MSB 13

// Reset values
`define RST_WORD 32'h00000000
`define RST_OBJ 6'h00
`endif

// file: verilog/can_moh_pkg.sv
package can_moh_pkg;
	typedef struct packed {
		logic        objectValid;
		logic        extendedFrameFlag;
		logic        direction;
		logic [28:0] id;
	} arb_t;

	typedef struct packed {
		logic        maskExtendedSelect;
		logic        maskSenseSelect;
		logic [28:0] acceptanceMaskBits;
	} mask_t;

	typedef struct packed {
		logic       newDataFlag;
		logic       messageLost;
		logic       interruptPending;
		logic       maskUse;
		logic       txIrqEnable;
		logic       receiveIrqEnable;
		logic       remoteEnable;
		logic       transmitRequest;
		logic       endOfBuffer;
		logic [3:0] dlc;
	} ctl_t;

	typedef struct packed {
		logic writeNotRead;
		logic maskTransfer;
		logic arbTransfer;
		logic controlTransfer;
		logic clearPending;
		logic transmitRequest;
		logic dataATransfer;
		logic dataBTransfer;
	} cmdmask_t;

	typedef enum logic {ST_IDLE, ST_SCAN} hstate_t;
endpackage

// file: verilog/can_moh_if.sv
`timescale 1ns/1ns
interface can_moh_if;
	logic                 cmdValid;
	can_moh_pkg::cmdmask_t cmdMask;
	logic [5:0]           objectNumber;
	can_moh_pkg::arb_t    ifArb;
	can_moh_pkg::mask_t   ifMask;
	can_moh_pkg::ctl_t    ifCtl;
	logic [63:0]          ifData;
	logic                 cmdDone;
	can_moh_pkg::arb_t    rdArb;
	can_moh_pkg::mask_t   rdMask;
	can_moh_pkg::ctl_t    rdCtl;
	logic [63:0]          rdData;
	logic [5:0]           intId;

	modport handler (
		input  cmdValid,
		input  cmdMask,
		input  objectNumber,
		input  ifArb,
		input  ifMask,
		input  ifCtl,
		input  ifData,
		output cmdDone,
		output rdArb,
		output rdMask,
		output rdCtl,
		output rdData,
		output intId
	);

	modport host (
		output cmdValid,
		output cmdMask,
		output objectNumber,
		output ifArb,
		output ifMask,
		output ifCtl,
		output ifData,
		input  cmdDone,
		input  rdArb,
		input  rdMask,
		input  rdCtl,
		input  rdData,
		input  intId
	);
endinterface // can_moh_if

// file: verilog/can_if_host.sv
`timescale 1ns/1ns
`include "can_moh_defs.svh"
module can_if_host (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata_ff,
	output logic             pready_ff,
	output logic             pslverr_ff,
	can_moh_if.host          ifc
);
	can_moh_pkg::cmdmask_t cmdMask_ff;
	can_moh_pkg::arb_t     arb_ff;
	can_moh_pkg::mask_t    mask_ff;
	can_moh_pkg::ctl_t     ctl_ff;
	logic [63:0]           data_ff;
	logic                  busy_ff;
	logic [5:0]            obj_ff;
	logic                  setup;
	logic                  wr;
	logic                  mapped;
	logic [31:0]           rdMux;

	assign setup = psel && !penable;
	assign wr = psel && penable && pready_ff && pwrite;
	assign ifc.cmdValid = busy_ff;
	assign ifc.cmdMask = cmdMask_ff;
	assign ifc.objectNumber = obj_ff;
	assign ifc.ifArb = arb_ff;
	assign ifc.ifMask = mask_ff;
	assign ifc.ifCtl = ctl_ff;
	assign ifc.ifData = data_ff;

	// Read mux and decode
	always_comb begin
		mapped = 1'b1;
		rdMux = `RST_WORD;
		case (paddr)
			`OFS_CMD_MASK: rdMux[7:0] = cmdMask_ff;
			`OFS_CMD_REQ: rdMux[5:0] = obj_ff;
			`OFS_ARB: rdMux = arb_ff;
			`OFS_MASK: rdMux[30:0] = mask_ff;
			`OFS_CTL: rdMux[12:0] = ctl_ff;
			`OFS_DATA_A: rdMux = data_ff[31:0];
			`OFS_DATA_B: rdMux = data_ff[63:32];
			`OFS_STATUS: begin
				rdMux[`STAT_BUSY_BIT] = busy_ff;
				rdMux[`STAT_INTID_MSB:`STAT_INTID_LSB] = ifc.intId;
			end
			default: mapped = 1'b0;
		endcase
	end

	// APB answer prepared in setup, so the access phase is one cycle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= `RST_WORD;
		end else begin
			pready_ff <= setup;
			pslverr_ff <= setup && !mapped;
			prdata_ff <= (setup && !pwrite) ? rdMux : `RST_WORD;
		end
	end

	// Transfer request; a new number is refused while one is in flight
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			busy_ff <= 1'b0;
			obj_ff <= `RST_OBJ;
		end else if (ifc.cmdDone) begin
			busy_ff <= 1'b0;
		end else if (wr && paddr == `OFS_CMD_REQ && !busy_ff) begin
			busy_ff <= 1'b1; // R20
			obj_ff <= pwdata[5:0]; // R3
		end
	end

	// Interface registers; read-back from the store wins over a write
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cmdMask_ff <= '0;
			arb_ff <= '0;
			mask_ff <= '0;
			ctl_ff <= '0;
			data_ff <= '0;
		end else begin
			if (wr && paddr == `OFS_CMD_MASK)
				cmdMask_ff <= pwdata[7:0]; // R3
			if (wr && paddr == `OFS_ARB)
				arb_ff <= pwdata; // R16
			if (wr && paddr == `OFS_MASK)
				mask_ff <= pwdata[30:0]; // R22
			if (wr && paddr == `OFS_CTL)
				ctl_ff <= pwdata[12:0]; // R17
			if (wr && paddr == `OFS_DATA_A)
				data_ff[31:0] <= pwdata; // R2
			if (wr && paddr == `OFS_DATA_B)
				data_ff[63:32] <= pwdata; // R2
			// Read-modify-write path keeps all bytes valid
			if (ifc.cmdDone && !cmdMask_ff.writeNotRead) begin
				if (cmdMask_ff.arbTransfer)
					arb_ff <= ifc.rdArb;
				if (cmdMask_ff.maskTransfer)
					mask_ff <= ifc.rdMask;
				if (cmdMask_ff.controlTransfer)
					ctl_ff <= ifc.rdCtl; // R10
				if (cmdMask_ff.dataATransfer)
					data_ff[31:0] <= ifc.rdData[31:0]; // R2
				if (cmdMask_ff.dataBTransfer)
					data_ff[63:32] <= ifc.rdData[63:32]; // R2
			end
		end
	end
endmodule // can_if_host

// file: test/can_moh_props.sv
`timescale 1ns/1ns
module can_moh_props #(
	parameter int NumObj = 32
) (
	input wire logic             clk,
	input wire logic             rst_b,
	input wire logic             cmdValid,
	input can_moh_pkg::cmdmask_t cmdMask,
	input wire logic [5:0]       objectNumber,
	input wire logic             cmdDone,
	input can_moh_pkg::ctl_t     rdCtl,
	input wire logic [63:0]      rdData,
	input wire logic [5:0]       intId
);
	// One domain, so one clock and one reset for all
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	// Transfer link handshake
	chk_done_has_req: assert property (cmdDone |-> cmdValid)
		else $error("transfer done without a request");
	chk_done_pulse: assert property (cmdDone |=> !cmdDone)
		else $error("transfer done longer than one cycle");
	chk_req_release: assert property (cmdDone |=> !cmdValid)
		else $error("request held after done");
	chk_done_bound: assert property (
		$rose(cmdValid) |-> ##[1:40] cmdDone)
		else $error("transfer not answered in time");
	// Read-back copies move only with a completed read
	chk_rd_on_done: assert property (
		$changed(rdData) || $changed(rdCtl) |-> cmdDone)
		else $error("read-back changed outside a transfer");
	chk_wr_keeps_rd: assert property (
		cmdDone && cmdMask.writeNotRead |-> $stable(rdData))
		else $error("write transfer disturbed read-back");
	chk_bad_obj: assert property (
		cmdDone && (objectNumber == 6'h00 || objectNumber > NumObj)
		|-> $stable(rdCtl))
		else $error("out-of-range object changed read-back");
	chk_intid_range: assert property (intId <= NumObj)
		else $error("pending identifier out of range");
	// Clearing the pointed object must move the pointer away
	chk_clear_pend: assert property (
		cmdDone && !cmdMask.writeNotRead && cmdMask.clearPending
		&& intId == objectNumber && intId != 6'h00
		|-> ##[1:3] intId != objectNumber)
		else $error("pending identifier kept after clear");

	cover property (cmdDone && cmdMask.writeNotRead);
	cover property (cmdDone && !cmdMask.writeNotRead);
	cover property (intId != 6'h00);
	cover property (rdCtl.messageLost);
endmodule // can_moh_props

// file: test/can_message_object_handler_tb_top.sv
`timescale 1ns/1ns
module can_message_object_handler_tb_top;
	localparam int Objs = 32;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        rxValid = 1'b0;
	logic [28:0] rxId = 29'h0;
	logic        rxXtd = 1'b0;
	logic        rxRemote = 1'b0;
	logic [3:0]  rxDlc = 4'h0;
	logic [63:0] rxData = 64'h0;
	logic        txReady = 1'b0;
	logic        txDone = 1'b0;
	logic        txFail = 1'b0;
	logic        txStart;
	logic [5:0]  txObj;
	logic [63:0] txData;
	logic [28:0] txId;
	logic        txXtd;
	logic        txRemote;
	logic [3:0]  txDlc;
	logic [31:0] rdat;
	logic        serr;
	int          starts = 0;
	int          mismatches = 0;
	int          comparisons = 0;

	can_moh_if link();

	can_if_host i_can_if_host (
		.clk(clk), .rst_b(rst_b), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata_ff(prdata), .pready_ff(pready), .pslverr_ff(pslverr),
		.ifc(link.host)
	);

	can_message_object_handler #(
		.NumObj(Objs)
	) i_can_message_object_handler (
		.clk(clk), .rst_b(rst_b), .ifc(link.handler), .rxValid(rxValid),
		.rxId(rxId), .rxXtd(rxXtd), .rxRemote(rxRemote), .rxDlc(rxDlc),
		.rxData(rxData), .txReady(txReady), .txDone(txDone), .txFail(txFail),
		.txStart_ff(txStart), .txObj_ff(txObj), .txId_ff(txId),
		.txXtd_ff(txXtd), .txRemote_ff(txRemote), .txDlc_ff(txDlc),
		.txData_ff(txData)
	);

	can_moh_props #(
		.NumObj(Objs)
	) i_can_moh_props (
		.clk(clk), .rst_b(rst_b), .cmdValid(link.cmdValid),
		.cmdMask(link.cmdMask), .objectNumber(link.objectNumber),
		.cmdDone(link.cmdDone), .rdCtl(link.rdCtl), .rdData(link.rdData),
		.intId(link.intId)
	);

	always #25 clk = ~clk;

	// Frame loads counted so silent cases can be shown silent
	always @(posedge clk) begin
		if (txStart === 1'b1) begin
			starts++;
		end
	end

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Request held until pready is seen high at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rdat = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Launch a transfer, then poll busy so no request overlaps
	task automatic xfer(input logic [7:0] m, input logic [5:0] o);
		int n = 0;
		apb(1'b1, 8'h00, {24'h0, m});
		apb(1'b1, 8'h04, {26'h0, o});
		do begin
			apb(1'b0, 8'h1C, 32'h0);
			n++;
		end while (rdat[0] !== 1'b0 && n < 40);
	endtask

	task automatic cfg(input logic [5:0] o, input logic [31:0] arb, msk, ctl,
		input logic [63:0] d);
		apb(1'b1, 8'h08, arb);
		apb(1'b1, 8'h0C, msk);
		apb(1'b1, 8'h10, ctl);
		apb(1'b1, 8'h14, d[31:0]);
		apb(1'b1, 8'h18, d[63:32]);
		xfer(8'hF3, o);
	endtask

	// Whole-object read that also clears new data and pending
	task automatic rdo(input logic [5:0] o, output logic [31:0] c,
		output logic [63:0] d);
		xfer(8'h7F, o);
		apb(1'b0, 8'h10, 32'h0);
		c = rdat;
		apb(1'b0, 8'h14, 32'h0);
		d[31:0] = rdat;
		apb(1'b0, 8'h18, 32'h0);
		d[63:32] = rdat;
	endtask

	// Frames followed by w idle cycles; w of 40 is more than a full scan
	task automatic frame(input logic [28:0] id, input logic x, r,
		input logic [3:0] dl, input logic [63:0] d, input int w);
		@(posedge clk);
		rxValid <= 1'b1;
		rxId <= id;
		rxXtd <= x;
		rxRemote <= r;
		rxDlc <= dl;
		rxData <= d;
		@(posedge clk);
		rxValid <= 1'b0;
		repeat (w) @(posedge clk);
	endtask

	task automatic txw(input logic [5:0] o, input logic [63:0] d);
		int n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (txStart !== 1'b1 && n < 80);
		check(txObj, o);
		check(txData, d);
	endtask

	task automatic fin;
		txDone <= 1'b1;
		@(posedge clk);
		txDone <= 1'b0;
	endtask

	// Two receive objects share an identifier; the lower one wins
	task automatic t_rx;
		logic [31:0] c;
		logic [63:0] d;
		cfg(6'h03, 32'h848C0000, 32'h0, 32'h98, 64'h0);
		cfg(6'h05, 32'h848C0000, 32'h0, 32'h98, 64'h0);
		frame(29'h048D5A5A, 1'b0, 1'b0, 4'h8, 64'h8877665544332211, 40);
		apb(1'b0, 8'h1C, 32'h0);
		check(rdat[13:8], 6'h03);
		frame(29'h048D5A5A, 1'b0, 1'b0, 4'h8, 64'hFFEEDDCCBBAA9988, 40);
		rdo(6'h03, c, d);
		check(c[12:0], 13'h1C98);
		check(d, 64'hFFEEDDCCBBAA9988);
		apb(1'b0, 8'h08, 32'h0);
		check(rdat & 32'hFFFC0000, 32'h848C0000);
		rdo(6'h05, c, d);
		check(c[12:0], 13'h0098);
		apb(1'b0, 8'h1C, 32'h0);
		check(rdat[13:8], 6'h00);
		rdo(6'h03, c, d);
		check(c[12:0], 13'h0898);
	endtask

	// Object number, not identifier, orders the queue
	task automatic t_tx;
		cfg(6'h09, 32'hE0000001, 32'h0, 32'h38, {8{8'h11}});
		cfg(6'h04, 32'hFFFFFFFF, 32'h0, 32'h38, {8{8'h44}});
		apb(1'b1, 8'h14, {4{8'h99}});
		apb(1'b1, 8'h18, {4{8'h99}});
		xfer(8'h87, 6'h09);
		txReady <= 1'b1;
		txw(6'h04, {8{8'h44}});
		apb(1'b1, 8'h10, 32'h1038);
		xfer(8'h90, 6'h04);
		fin;
		txw(6'h04, {8{8'h44}});
		fin;
		txw(6'h09, {8{8'h99}});
		fin;
	endtask

	// The three remote-frame setups of a transmit object
	task automatic t_rem;
		logic [31:0] c;
		logic [63:0] d;
		int s;
		cfg(6'h0A, 32'hEAAAAAAA, 32'h0, 32'h58, {8{8'hA0}});
		cfg(6'h0B, 32'hEBBBBBBB, 32'h0, 32'h18, {8{8'hB0}});
		cfg(6'h0C, 32'hECCCCCCC, 32'h5FFFFFFF, 32'h218, {8{8'hC0}});
		frame(29'h0AAAAAAA, 1'b1, 1'b1, 4'h8, 64'h0, 0);
		txw(6'h0A, {8{8'hA0}});
		fin;
		s = starts;
		frame(29'h0BBBBBBB, 1'b1, 1'b1, 4'h8, 64'h0, 40);
		frame(29'h0CCCCCCC, 1'b1, 1'b1, 4'h5, 64'h0, 40);
		check(starts - s, 0);
		rdo(6'h0B, c, d);
		check(c[12:0], 13'h0018);
		rdo(6'h0C, c, d);
		check(c[12:0] & 13'h1E3F, 13'h1215);
		check(d, {8{8'hC0}});
	endtask

	// Receive object asks for data; a failed try is retried
	task automatic t_req;
		logic [31:0] c;
		logic [63:0] d;
		int s;
		txReady <= 1'b0;
		cfg(6'h02, 32'h81400000, 32'h0, 32'h38, 64'h0);
		txReady <= 1'b1;
		txw(6'h02, 64'h0);
		check(txRemote, 1'b1);
		check(txId, 29'h01400000);
		check(txXtd, 1'b0);
		check(txDlc, 4'h8);
		txFail <= 1'b1;
		@(posedge clk);
		txFail <= 1'b0;
		txw(6'h02, 64'h0);
		frame(29'h01400000, 1'b0, 1'b0, 4'h8, 64'h1234, 40);
		s = starts;
		fin;
		repeat (5) @(posedge clk);
		check(starts - s, 0);
		rdo(6'h02, c, d);
		check(c[12:0], 13'h1018);
		check(d, 64'h1234);
	endtask

	// Unmapped address and out-of-range objects are refused
	task automatic t_bad;
		apb(1'b1, 8'h20, 32'hFFFFFFFF);
		check(serr, 1'b1);
		xfer(8'h7F, 6'h00);
		xfer(8'h7F, 6'h21);
		apb(1'b0, 8'h1C, 32'h0);
		check(rdat[0], 1'b0);
	endtask

	task automatic conclude;
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		t_rx;
		t_tx;
		t_rem;
		t_req;
		t_bad;
		conclude;
	end

	// Run needs well under a thousand cycles; far beyond that is a hang
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		conclude;
	end
endmodule // can_message_object_handler_tb_top
